/* File: uhpled_dev_model.sv */
// Behavioural model of the device attached to the downstream port.
`timescale 1ns/1ps
`include "uhpled_regs.svh"
module uhpled_dev_model (
  // Clock.
  input  wire logic       ref_clk,
  // Line seen by the host transceiver.
  output logic      [1:0] line_condition,
  output logic            hs_disconnect
);
  initial begin
    line_condition = `UHPLED_LINE_J;
    hs_disconnect  = 1'b0;
  end
  // Sets a line level and keeps it for n clock cycles.
  task automatic hold(input logic [1:0] code, input int n);
    line_condition = code;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Answers a bus reset: waits under the host SE0, then chirps K for len cycles.
  task automatic chirp(input int dly, input int len);
    hold(`UHPLED_LINE_SE0, dly);
    hold(`UHPLED_LINE_K, len);
  endtask
  task automatic hs_gone(input logic gone);
    hs_disconnect = gone;
  endtask
endmodule

/* File: uhpled_events_sva.sv */
// Concurrent checks on the host port line event detector ports.
`timescale 1ns/1ps
`include "uhpled_regs.svh"
module uhpled_events_sva
  import uhpled_pkg::*;
#(
  parameter int CHIRP_MIN_CYC = `UHPLED_CHIRP_MIN_CYC,
  parameter int CHIRP_END_CYC = `UHPLED_CHIRP_END_CYC
) (
  // Clock and reset.
  input wire logic          ref_clk,
  input wire logic          sys_rst,
  // Firmware and line inputs.
  input wire logic          cmd_write,
  input wire logic [2:0]    host_state_command,
  input wire logic          wake_request_watch_enable,
  input wire logic [3:0]    status_clear,
  input wire logic [1:0]    line_condition,
  input wire logic          hs_mode,
  // Design outputs.
  input wire uhpled_state_e host_state,
  input wire logic          resume_k_drive,
  input wire logic          detach_watch_on,
  input wire logic          wake_watch_on,
  input wire logic          chirp_watch_on,
  input wire logic [3:0]    host_event_status_0
);
  logic [15:0] k_run;
  logic [15:0] se0_run;
  logic [15:0] last_k;
  logic [19:0] rst_age;
  logic [3:0]  st;
  assign st = host_event_status_0;
  // Raw run lengths of K and SE0 and the age of the last bus reset command.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      k_run   <= 16'h0;
      se0_run <= 16'h0;
      last_k  <= 16'h0;
      rst_age <= 20'h0;
    end else begin
      k_run   <= (line_condition != `UHPLED_LINE_K) ? 16'h0 : k_run + 16'(~&k_run);
      se0_run <= (line_condition != `UHPLED_LINE_SE0) ? 16'h0 : se0_run + 16'(~&se0_run);
      if (line_condition != `UHPLED_LINE_K && k_run != 16'h0)
        last_k <= k_run;
      rst_age <= (cmd_write && host_state_command == `UHPLED_CMD_BUS_RESET) ? 20'h0
               : rst_age + 20'(~&rst_age);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence wake_cmd_s;
    cmd_write && host_state_command == `UHPLED_CMD_WAKE_PORT;
  endsequence
  sequence reset_cmd_s;
    cmd_write && host_state_command == `UHPLED_CMD_BUS_RESET;
  endsequence
  detach_states_a: assert property (
    detach_watch_on |-> host_state inside {UHPLED_ST_DISABLED, UHPLED_ST_OPERATIONAL,
                                           UHPLED_ST_SUSPEND})
    else $error("detach watch active in a wrong state");
  hs_detach_a: assert property (
    detach_watch_on && hs_mode |-> host_state == UHPLED_ST_OPERATIONAL)
    else $error("high-speed detach watch outside operational");
  fs_filter_a: assert property (
    $rose(st[`UHPLED_BIT_DETACH]) && !$past(hs_mode) |-> se0_run >= `UHPLED_FILT_CYC)
    else $error("detach flagged on a short SE0");
  wake_gate_a: assert property (
    wake_watch_on |-> host_state == UHPLED_ST_SUSPEND && wake_request_watch_enable)
    else $error("wakeup watch active while not allowed");
  wake_filter_a: assert property (
    $rose(st[`UHPLED_BIT_WAKE]) |-> k_run >= `UHPLED_FILT_CYC)
    else $error("wakeup flagged on a short K");
  resume_start_a: assert property (
    wake_cmd_s |=> resume_k_drive)
    else $error("resume K not driven after wake command");
  chirp_start_a: assert property (
    reset_cmd_s |=> chirp_watch_on)
    else $error("chirp watch not started by bus reset");
  chirp_good_a: assert property (
    $rose(st[`UHPLED_BIT_CHIRP_GOOD]) |-> last_k >= CHIRP_MIN_CYC && rst_age < CHIRP_END_CYC + 3)
    else $error("chirp good without a long chirp in time");
  good_stop_a: assert property (
    $rose(st[`UHPLED_BIT_CHIRP_GOOD]) |-> ##[0:1] !chirp_watch_on)
    else $error("chirp watch still on after chirp good");
  fail_time_a: assert property (
    $rose(st[`UHPLED_BIT_CHIRP_FAIL]) |-> rst_age >= CHIRP_END_CYC - 1 && rst_age <= CHIRP_END_CYC + 3)
    else $error("chirp fail at a wrong time");
  resume_quiet_a: assert property (
    resume_k_drive |-> !detach_watch_on && !wake_watch_on)
    else $error("detach or wakeup watch on during resume");
  sticky_flags_a: assert property (
    ($past(st) & ~$past(status_clear) & ~st) == 4'h0)
    else $error("event flag dropped without a clear");
endmodule

/* File: uhpled_hold_timer.sv */
// Counts how long a condition holds without a break and pulses when it reaches LIMIT cycles.
`timescale 1ns/1ps
module uhpled_hold_timer #(
  parameter int LIMIT = 313
) (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Watched condition and results.
  input  wire logic hold,
  output logic      hit,
  output logic      held
);

  localparam int CW = $clog2(LIMIT + 1);

  if (LIMIT < 2) begin : g_bad_limit
    $error("uhpled_hold_timer needs LIMIT of at least 2");
  end

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          at_limit;

  assign at_limit   = (count_reg == CW'(LIMIT));
  assign count_next = !hold ? '0 : (at_limit ? count_reg : count_reg + 1'b1);
  assign hit        = hold && (count_reg == CW'(LIMIT - 1));
  assign held       = at_limit;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

/* File: uhpled_line_sync.sv */
// Three-stage synchroniser whose output moves once stages two and three agree.
`timescale 1ns/1ps
module uhpled_line_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Asynchronous input and settled output.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  assign out_next = (stage2_reg == stage3_reg) ? stage3_reg : out_reg;
  assign sync_out = out_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      out_reg    <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      out_reg    <= out_next;
    end
  end

endmodule

/* File: uhpled_pkg.sv */
// Types shared by the host port line event detectors.
package uhpled_pkg;

  typedef enum logic [2:0] {
    UHPLED_ST_IDLE,
    UHPLED_ST_AWAIT_ATTACH,
    UHPLED_ST_DISABLED,
    UHPLED_ST_RESET,
    UHPLED_ST_OPERATIONAL,
    UHPLED_ST_SUSPEND,
    UHPLED_ST_RESUME
  } uhpled_state_e;

endpackage

/* File: uhpled_port_events.sv */
// Host port state keeping with detach, remote wakeup and device chirp detection.
`timescale 1ns/1ps
`include "uhpled_regs.svh"

// Contract
// - Watch for detach while disabled, operational or suspended.
// - High-speed detach is watched only while operational.
// - High-speed detach needs three disconnected samples in consecutive SOF EOP windows.
// - Full/low-speed detach flagged only after SE0 held over 2.5 us.
// - Wakeup watch only in suspend and only when its enable is on.
// - K held over 2.5 us in suspend raises the wakeup flag.
// - Resume K starts within 1 ms of the device wakeup start; the block starts it only on the firmware wake command.
// - Wakeup detection behaves the same at high, full and low speed.
// - Chirp watch starts when firmware writes the bus reset command.
// - A chirp is recognised once K holds over 2.5 us.
// - Chirp over 1 ms ending in SE0 before 7 ms sets chirp good.
// - Chirp watch stops when chirp good is raised.
// - No chirp end by 7 ms sets chirp fail and stops the watch.
// - Detach and wakeup watches stay off while resume is driven.
module uhpled_port_events
  import uhpled_pkg::*;
#(
  parameter int CHIRP_MIN_CYC = `UHPLED_CHIRP_MIN_CYC,
  parameter int CHIRP_END_CYC = `UHPLED_CHIRP_END_CYC,
  parameter int RESUME_CYC    = `UHPLED_RESUME_CYC
) (
  // Clock and reset.
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  // Firmware command port.
  input  wire logic                         cmd_write,
  input  wire logic [2:0]                   host_state_command,
  input  wire logic                         wake_request_watch_enable,
  input  wire logic [`UHPLED_STATUS_W-1:0]  status_clear,
  // Port and transceiver inputs.
  input  wire logic [1:0]                   line_condition,
  input  wire logic                         hs_disconnect,
  input  wire logic                         hs_mode,
  input  wire logic                         sof_eop_window,
  // Host state and line drive.
  output uhpled_state_e                     host_state,
  output logic                              resume_k_drive,
  output logic                              reset_se0_drive,
  // Watch status.
  output logic                              detach_watch_on,
  output logic                              wake_watch_on,
  output logic                              chirp_watch_on,
  output logic                              chirp_seen,
  // Event flags.
  output logic                              detach_seen_flag,
  output logic                              wake_request_seen_flag,
  output logic                              chirp_good_flag,
  output logic                              chirp_fail_flag,
  output logic [`UHPLED_STATUS_W-1:0]       host_event_status_0
);

  localparam int END_W = $clog2(CHIRP_END_CYC + 1);
  localparam int RES_W = $clog2(RESUME_CYC + 1);

  if (CHIRP_END_CYC <= CHIRP_MIN_CYC || CHIRP_MIN_CYC <= `UHPLED_FILT_CYC) begin : g_bad_chirp
    $error("uhpled_port_events needs FILT < CHIRP_MIN < CHIRP_END cycles");
  end
  if (RESUME_CYC < 2) begin : g_bad_resume
    $error("uhpled_port_events needs RESUME_CYC of at least 2");
  end

  // Settled copies of the transceiver lines. Line condition and the high-speed envelope
  // share one synchroniser, so both settle on the same edge and a one-cycle glitch that
  // only one stage saw is never taken.
  logic [1:0] line_s;
  logic       hs_disc_s;

  uhpled_line_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({hs_disconnect, line_condition}),
    .sync_out ({hs_disc_s, line_s})
  );

  wire line_se0 = (line_s == `UHPLED_LINE_SE0);
  wire line_k   = (line_s == `UHPLED_LINE_K);

  // Command decode. Code 0 matches no decode wire, so a strobe carrying it leaves
  // the state alone.
  wire cmd_idle   = cmd_write && (host_state_command == `UHPLED_CMD_IDLE);
  wire cmd_await  = cmd_write && (host_state_command == `UHPLED_CMD_AWAIT_ATTACH);
  wire cmd_dis    = cmd_write && (host_state_command == `UHPLED_CMD_DISABLED);
  wire cmd_reset  = cmd_write && (host_state_command == `UHPLED_CMD_BUS_RESET);
  wire cmd_oper   = cmd_write && (host_state_command == `UHPLED_CMD_OPERATIONAL);
  wire cmd_susp   = cmd_write && (host_state_command == `UHPLED_CMD_SUSPEND);
  wire cmd_wake   = cmd_write && (host_state_command == `UHPLED_CMD_WAKE_PORT);

  uhpled_state_e state_reg;
  uhpled_state_e state_next;
  logic [RES_W-1:0] resume_cnt_reg;
  logic [RES_W-1:0] resume_cnt_next;
  wire resume_done = (state_reg == UHPLED_ST_RESUME) && (resume_cnt_reg == RES_W'(RESUME_CYC - 1));

  // A command wins over the automatic return from resume.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      // These states wait for firmware; only a command moves them.
      UHPLED_ST_IDLE,
      UHPLED_ST_AWAIT_ATTACH,
      UHPLED_ST_DISABLED,
      UHPLED_ST_RESET,
      UHPLED_ST_OPERATIONAL,
      UHPLED_ST_SUSPEND: begin
        state_next = state_reg;
      end
      // Resume ends by itself once the K has been driven for its full length.
      UHPLED_ST_RESUME: begin
        if (resume_done) begin
          state_next = UHPLED_ST_OPERATIONAL;
        end
      end
      // The one unused encoding falls back to idle.
      default: begin
        state_next = UHPLED_ST_IDLE;
      end
    endcase
    if (cmd_idle) begin
      state_next = UHPLED_ST_IDLE;
    end else if (cmd_await) begin
      state_next = UHPLED_ST_AWAIT_ATTACH;
    end else if (cmd_dis) begin
      state_next = UHPLED_ST_DISABLED;
    end else if (cmd_reset) begin
      state_next = UHPLED_ST_RESET;
    end else if (cmd_oper) begin
      state_next = UHPLED_ST_OPERATIONAL;
    end else if (cmd_susp) begin
      state_next = UHPLED_ST_SUSPEND;
    end else if (cmd_wake) begin
      state_next = UHPLED_ST_RESUME;
    end
  end

  // Resume K is driven from the cycle after the wake command is taken.
  // The count stops at its end value, so it cannot wrap if the return is held off.
  // Reset SE0 follows the state directly; the line drivers sit outside this block.
  assign resume_cnt_next = (state_reg != UHPLED_ST_RESUME) ? '0 :
                           (resume_done ? resume_cnt_reg : resume_cnt_reg + 1'b1);
  assign resume_k_drive  = (state_reg == UHPLED_ST_RESUME);
  assign reset_se0_drive = (state_reg == UHPLED_ST_RESET);
  assign host_state      = state_reg;

  // Detach watches; resume is excluded by naming only the three watched states.
  // High speed narrows the watch to operational; full and low speed use all three.
  wire detach_state = (state_reg == UHPLED_ST_DISABLED) ||
                      (state_reg == UHPLED_ST_OPERATIONAL) ||
                      (state_reg == UHPLED_ST_SUSPEND);
  wire hs_watch = hs_mode && (state_reg == UHPLED_ST_OPERATIONAL);
  wire fs_watch = !hs_mode && detach_state;
  assign detach_watch_on = hs_watch || fs_watch;

  // High-speed detach: the run of bad samples moves only on a window pulse. Cycles
  // between windows neither add to it nor break it, a clean sample empties it, and
  // leaving the watch starts it over. The run stops at its end value.
  logic [1:0] hs_miss_reg;
  logic [1:0] hs_miss_next;
  wire hs_sample_bad = hs_watch && sof_eop_window && hs_disc_s;
  wire hs_detach_hit = hs_sample_bad &&
                       (hs_miss_reg == 2'(`UHPLED_HS_DETACH_SAMPLES - 1));
  assign hs_miss_next = !hs_watch ? 2'h0 :
                        !sof_eop_window ? hs_miss_reg :
                        !hs_disc_s ? 2'h0 :
                        hs_detach_hit ? hs_miss_reg : hs_miss_reg + 2'h1;

  // Full/low-speed detach: the timer fires once per unbroken run of settled SE0, so a
  // device that stays away sets the flag once and a short SE0 dip never sets it.
  logic fs_detach_hit;
  uhpled_hold_timer #(
    .LIMIT (`UHPLED_FILT_CYC)
  ) u_fs_detach (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .hold    (fs_watch && line_se0),
    .hit     (fs_detach_hit),
    .held    ()
  );

  // Wakeup watch is blind to port speed. Leaving suspend or dropping the enable empties
  // the timer, so a K already on the line is timed afresh when the watch opens.
  assign wake_watch_on = (state_reg == UHPLED_ST_SUSPEND) && wake_request_watch_enable;
  logic wake_hit;
  uhpled_hold_timer #(
    .LIMIT (`UHPLED_FILT_CYC)
  ) u_wake (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .hold    (wake_watch_on && line_k),
    .hit     (wake_hit),
    .held    ()
  );

  // Chirp watch and the time since the reset command. The timer stops at its end value
  // and chirp good is blocked from that cycle on, so the two outcomes never rise together.
  // The short timer only marks a recognised chirp; the long one decides whether it counts.
  logic chirp_on_reg;
  logic chirp_on_next;
  logic chirp_seen_reg;
  logic chirp_long_reg;
  logic [END_W-1:0] reset_time_reg;
  logic [END_W-1:0] reset_time_next;
  logic chirp_k_hit;
  logic chirp_long_hit;

  uhpled_hold_timer #(
    .LIMIT (`UHPLED_FILT_CYC)
  ) u_chirp_k (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .hold    (chirp_on_reg && line_k),
    .hit     (chirp_k_hit),
    .held    ()
  );

  uhpled_hold_timer #(
    .LIMIT (CHIRP_MIN_CYC)
  ) u_chirp_long (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .hold    (chirp_on_reg && line_k),
    .hit     (chirp_long_hit),
    .held    ()
  );

  // Time up marks the end of the chirp window counted from the reset command.
  wire time_up    = (reset_time_reg == END_W'(CHIRP_END_CYC));
  wire chirp_good = chirp_on_reg && chirp_long_reg && line_se0 && !time_up;
  wire chirp_fail = chirp_on_reg && time_up && !chirp_good;

  assign chirp_on_next = cmd_reset ? 1'b1 :
                         (chirp_good || chirp_fail || state_next != UHPLED_ST_RESET) ? 1'b0 :
                         chirp_on_reg;
  assign reset_time_next = cmd_reset ? '0 :
                           (chirp_on_reg && !time_up) ? reset_time_reg + 1'b1 : reset_time_reg;
  assign chirp_watch_on = chirp_on_reg;
  assign chirp_seen     = chirp_seen_reg;

  // Sticky flags: a set in the same cycle as its clear wins, so an event that lands on
  // the clear is still reported at the next poll.
  logic [`UHPLED_STATUS_W-1:0] flags_reg;
  logic [`UHPLED_STATUS_W-1:0] flag_set;
  assign flag_set[`UHPLED_BIT_DETACH]     = hs_detach_hit || fs_detach_hit;
  assign flag_set[`UHPLED_BIT_WAKE]       = wake_hit;
  assign flag_set[`UHPLED_BIT_CHIRP_GOOD] = chirp_good;
  assign flag_set[`UHPLED_BIT_CHIRP_FAIL] = chirp_fail;

  assign host_event_status_0    = flags_reg;
  assign detach_seen_flag       = flags_reg[`UHPLED_BIT_DETACH];
  assign wake_request_seen_flag = flags_reg[`UHPLED_BIT_WAKE];
  assign chirp_good_flag        = flags_reg[`UHPLED_BIT_CHIRP_GOOD];
  assign chirp_fail_flag        = flags_reg[`UHPLED_BIT_CHIRP_FAIL];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg      <= UHPLED_ST_IDLE;
      resume_cnt_reg <= '0;
      hs_miss_reg    <= 2'h0;
      flags_reg      <= '0;
    end else begin
      state_reg      <= state_next;
      resume_cnt_reg <= resume_cnt_next;
      hs_miss_reg    <= hs_miss_next;
      flags_reg      <= flag_set | (flags_reg & ~status_clear);
    end
  end

  // A K that ends before the long mark, or ends in anything but SE0, starts the search over.
  // A new reset command also empties both marks, whatever the line shows.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chirp_on_reg   <= 1'b0;
      chirp_seen_reg <= 1'b0;
      chirp_long_reg <= 1'b0;
      reset_time_reg <= '0;
    end else begin
      chirp_on_reg   <= chirp_on_next;
      reset_time_reg <= reset_time_next;
      if (cmd_reset || !chirp_on_reg || !line_k) begin
        chirp_seen_reg <= 1'b0;
        chirp_long_reg <= 1'b0;
      end else begin
        chirp_seen_reg <= chirp_seen_reg || chirp_k_hit;
        chirp_long_reg <= chirp_long_reg || chirp_long_hit;
      end
    end
  end

endmodule

/* File: uhpled_port_events_tb_top.sv */
// Self-checking bench for the host port line event detectors.
`timescale 1ns/1ps
`include "uhpled_regs.svh"
module uhpled_port_events_tb_top
  import uhpled_pkg::*;
;
  localparam int D = `UHPLED_BIT_DETACH;
  localparam int W = `UHPLED_BIT_WAKE;
  localparam int G = `UHPLED_BIT_CHIRP_GOOD;
  localparam int F = `UHPLED_BIT_CHIRP_FAIL;
  logic          ref_clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          cmd_write = 1'b0;
  logic [2:0]    host_state_command = 3'h0;
  logic          wake_request_watch_enable = 1'b0;
  logic [3:0]    status_clear = 4'h0;
  logic          hs_mode = 1'b0;
  logic          sof_eop_window = 1'b0;
  wire  [1:0]    line_condition;
  wire           hs_disconnect;
  uhpled_state_e host_state;
  logic          resume_k_drive;
  logic          detach_watch_on;
  logic          wake_watch_on;
  logic          chirp_watch_on;
  logic          chirp_seen;
  logic          se0_drive;
  logic [3:0]    flg;
  logic [3:0]    st;
  int            miscompares = 0;
  int            n_checks = 0;
  int            cycles = 0;
  uhpled_port_events #(.CHIRP_MIN_CYC(400), .CHIRP_END_CYC(1000), .RESUME_CYC(50)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_write(cmd_write),
    .host_state_command(host_state_command), .status_clear(status_clear),
    .wake_request_watch_enable(wake_request_watch_enable), .line_condition(line_condition),
    .hs_disconnect(hs_disconnect), .hs_mode(hs_mode), .sof_eop_window(sof_eop_window),
    .host_state(host_state), .resume_k_drive(resume_k_drive), .reset_se0_drive(se0_drive),
    .detach_watch_on(detach_watch_on), .wake_watch_on(wake_watch_on),
    .chirp_watch_on(chirp_watch_on), .chirp_seen(chirp_seen), .detach_seen_flag(flg[D]),
    .wake_request_seen_flag(flg[W]), .chirp_good_flag(flg[G]), .chirp_fail_flag(flg[F]),
    .host_event_status_0(st));
  uhpled_dev_model u_dev (.ref_clk(ref_clk), .line_condition(line_condition),
    .hs_disconnect(hs_disconnect));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic cmd(input logic [2:0] code);
    cmd_write = 1'b1;
    host_state_command = code;
    tick(1);
    cmd_write = 1'b0;
    tick(1);
  endtask
  task automatic clear_all();
    status_clear = 4'hf;
    tick(1);
    status_clear = 4'h0;
  endtask
  task automatic sof(input int n);
    repeat (n) begin
      sof_eop_window = 1'b1;
      tick(1);
      sof_eop_window = 1'b0;
      tick(7);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    tick(10);
    sys_rst = 1'b0;
    u_dev.hold(`UHPLED_LINE_SE0, 400);
    check(st[D] === 1'b0, "detach flagged in idle");
    u_dev.hold(`UHPLED_LINE_J, 5);
    cmd(`UHPLED_CMD_OPERATIONAL);
    u_dev.hold(`UHPLED_LINE_SE0, 200);
    u_dev.hold(`UHPLED_LINE_J, 10);
    check(st[D] === 1'b0, "short SE0 flagged");
    u_dev.hold(`UHPLED_LINE_SE0, 330);
    check(st[D] === 1'b1 && flg[D] === 1'b1, "detach missed");
    u_dev.hold(`UHPLED_LINE_J, 10);
    check(st[D] === 1'b1, "flag lost");
    clear_all();
    check(st[D] === 1'b0, "flag not cleared");
    cmd(`UHPLED_CMD_AWAIT_ATTACH);
    cmd(`UHPLED_CMD_DISABLED);
    u_dev.hold(`UHPLED_LINE_SE0, 330);
    check(st[D] === 1'b1, "detach missed while disabled");
    u_dev.hold(`UHPLED_LINE_J, 10);
    clear_all();
    hs_mode = 1'b1;
    cmd(`UHPLED_CMD_SUSPEND);
    u_dev.hs_gone(1'b1);
    sof(3);
    check(st[D] === 1'b0, "HS detach outside operational");
    cmd(`UHPLED_CMD_OPERATIONAL);
    sof(2);
    check(st[D] === 1'b0, "HS detach after two samples");
    sof(1);
    check(st[D] === 1'b1, "HS detach missed");
    u_dev.hs_gone(1'b0);
    clear_all();
    hs_mode = 1'b0;
    cmd(`UHPLED_CMD_SUSPEND);
    u_dev.hold(`UHPLED_LINE_K, 400);
    u_dev.hold(`UHPLED_LINE_J, 10);
    check(st[W] === 1'b0, "wakeup flagged while disabled");
    wake_request_watch_enable = 1'b1;
    for (int hs = 0; hs < 2; hs++) begin
      hs_mode = hs[0];
      u_dev.hold(`UHPLED_LINE_K, 330);
      check(st[W] === 1'b1 && flg[W] === 1'b1, "wakeup missed");
      u_dev.hold(`UHPLED_LINE_J, 10);
      clear_all();
    end
    hs_mode = 1'b0;
    u_dev.hold(`UHPLED_LINE_K, 330);
    cmd(`UHPLED_CMD_WAKE_PORT);
    check(resume_k_drive === 1'b1, "resume not driven");
    check({wake_watch_on, detach_watch_on} === 2'b00, "watch on in resume");
    clear_all();
    u_dev.hold(`UHPLED_LINE_K, 400);
    check(host_state === UHPLED_ST_OPERATIONAL, "resume did not end");
    check(st[W] === 1'b0, "wakeup flagged outside suspend");
    cmd(`UHPLED_CMD_BUS_RESET);
    check(chirp_watch_on === 1'b1, "chirp watch not started");
    check(se0_drive === 1'b1, "reset SE0 not driven");
    u_dev.chirp(20, 450);
    u_dev.hold(`UHPLED_LINE_SE0, 6);
    check(st[G] === 1'b1 && chirp_watch_on === 1'b0, "good chirp missed");
    check(flg[G] === 1'b1, "chirp good pin low");
    u_dev.hold(`UHPLED_LINE_SE0, 700);
    check(st[F] === 1'b0, "fail after good chirp");
    clear_all();
    cmd(`UHPLED_CMD_BUS_RESET);
    u_dev.chirp(20, 340);
    check(chirp_seen === 1'b1, "chirp not recognised");
    u_dev.hold(`UHPLED_LINE_SE0, 6);
    check(st[G] === 1'b0, "short chirp passed");
    u_dev.hold(`UHPLED_LINE_SE0, 700);
    check(st[F] === 1'b1 && chirp_watch_on === 1'b0, "chirp fail missing");
    check(flg[F] === 1'b1, "chirp fail pin low");
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    tick(1);
    check(st === 4'h0 && host_state === UHPLED_ST_IDLE, "reset state wrong");
    check(flg === 4'h0 && se0_drive === 1'b0, "pins not cleared by reset");
    wrap_up();
  end
endmodule
bind uhpled_port_events uhpled_events_sva #(
  .CHIRP_MIN_CYC(CHIRP_MIN_CYC), .CHIRP_END_CYC(CHIRP_END_CYC)
) u_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_write(cmd_write),
  .host_state_command(host_state_command), .status_clear(status_clear),
  .wake_request_watch_enable(wake_request_watch_enable), .line_condition(line_condition),
  .hs_mode(hs_mode), .host_state(host_state), .resume_k_drive(resume_k_drive),
  .detach_watch_on(detach_watch_on), .wake_watch_on(wake_watch_on),
  .chirp_watch_on(chirp_watch_on), .host_event_status_0(host_event_status_0));

/* File: uhpled_regs.svh */
// Constants for the host port line event detectors: line codes, commands, flag bits, timings.
`ifndef UHPLED_REGS_SVH
`define UHPLED_REGS_SVH

// Transceiver line condition codes.
`define UHPLED_LINE_SE0 2'h0
`define UHPLED_LINE_J 2'h1
`define UHPLED_LINE_K 2'h2

// Host state command codes.
`define UHPLED_CMD_IDLE 3'h1
`define UHPLED_CMD_AWAIT_ATTACH 3'h2
`define UHPLED_CMD_DISABLED 3'h3
`define UHPLED_CMD_BUS_RESET 3'h4
`define UHPLED_CMD_OPERATIONAL 3'h5
`define UHPLED_CMD_SUSPEND 3'h6
`define UHPLED_CMD_WAKE_PORT 3'h7

// Bit positions in host_event_status_0.
`define UHPLED_BIT_DETACH 0
`define UHPLED_BIT_WAKE 1
`define UHPLED_BIT_CHIRP_GOOD 2
`define UHPLED_BIT_CHIRP_FAIL 3
`define UHPLED_STATUS_W 4

// Timing in ns, the clock period and the high-speed detach sample count.
`define UHPLED_CLK_PERIOD_NS 8
`define UHPLED_FILT_NS 2500
`define UHPLED_CHIRP_MIN_NS 1000000
`define UHPLED_CHIRP_END_NS 7000000
`define UHPLED_RESUME_NS 20000000
`define UHPLED_HS_DETACH_SAMPLES 3

// Least times round up, and one more cycle makes the hold strictly longer.
`define UHPLED_FILT_CYC ((`UHPLED_FILT_NS + `UHPLED_CLK_PERIOD_NS - 1) / `UHPLED_CLK_PERIOD_NS)
`define UHPLED_CHIRP_MIN_CYC (`UHPLED_CHIRP_MIN_NS / `UHPLED_CLK_PERIOD_NS + 1)
`define UHPLED_CHIRP_END_CYC (`UHPLED_CHIRP_END_NS / `UHPLED_CLK_PERIOD_NS)
`define UHPLED_RESUME_CYC (`UHPLED_RESUME_NS / `UHPLED_CLK_PERIOD_NS)

`endif
